// [rtl/core_flags_and_interrupt_logic.sv]
// data-space pointers, working register, flags and two-source interrupt unit
`timescale 1ns/1ps
`include "core_flags_regs.svh"
module core_flags_and_interrupt_logic #(
  parameter int STACK_LEVELS = `STACK_LEVELS,
  parameter int RAM_DEPTH = `RAM_DEPTH
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata_ff,
  output logic mem_rvalid_ff,
  input wire logic alu_go,
  input wire core_flags_pkg::alu_op_t alu_op,
  input wire logic [7:0] alu_operand,
  input wire logic alu_into_mem,
  input wire logic alu_skip_if_zero,
  input wire logic alu_skip_if_nonzero,
  output logic skip_ff,
  input wire logic halt_exec,
  input wire logic wdt_clear_exec,
  input wire logic wdt_timeout,
  input wire logic call_push,
  input wire logic ret_pop,
  input wire logic return_from_irq_pop,
  input wire logic irq_slot,
  input wire logic tick_overflow,
  input wire logic shared_irq_pin,
  input wire logic edge_polarity_select_line,
  output logic irq_take_ff,
  output logic [11:0] irq_vector_ff,
  output logic stack_full_ff,
  output logic wake_ff,
  output logic halted_ff,
  output logic [7:0] working_register_ff,
  output logic [7:0] result_flags_ff
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] memory_pointer_0_ff; // pointer behind 00H
  logic [7:0] memory_pointer_1_ff; // pointer behind 02H
  logic global_irq_enable_ff; // master enable
  logic pin_irq_enable_ff; // pin source enable
  logic tick_irq_enable_ff; // timer source enable
  logic pin_irq_pending_ff; // pin request latched
  logic tick_irq_pending_ff; // timer request latched
  logic pin_prev_ff; // last sample of the pin
  logic pin_seen_ff; // pin sampled once since reset
  logic [2:0] stack_level_ff; // return stack occupancy
  logic rd_pend_ff; // read in flight
  logic rd_ram_ff; // read in flight targets ram
  logic [7:0] rd_reg_ff; // register read data, first stage
  logic [7:0] ram_q; // ram read data
  core_flags_pkg::power_state_t pwr_ff; // run or halted
  logic [7:0] eff_addr; // address after indirection
  logic eff_dead; // indirection through an indirection address
  logic wr_any; // a data-space write this cycle
  logic [7:0] wr_byte; // the byte being written
  logic wr_ok; // write allowed after indirection
  logic in_ram; // effective address inside ram
  logic [7:0] ram_idx; // ram index
  logic [7:0] reg_rdata; // register read mux
  logic alu_to_work; // alu result lands in the working register
  logic pin_event; // chosen edge on the pin
  logic want_pin; // pin request enabled
  logic want_tick; // timer request enabled
  logic take_pin; // acknowledge pin this cycle
  logic take_tick; // acknowledge timer this cycle
  logic ctrl_wr; // software write to irq_control_reg
  logic [2:0] nxt_stack_level; // stack occupancy next
  logic wake_cause; // anything that ends halt
  alu_if alu_bus (); // alu carrier

  ////////////////////////////////////////////////////////////////////////
  // alu hookup: working register and operand in, flags held as carry inputs
  assign alu_bus.op = alu_op;
  assign alu_bus.a = working_register_ff;
  assign alu_bus.b = alu_operand;
  assign alu_bus.cin = result_flags_ff[`BIT_CARRY];
  assign alu_bus.hin = result_flags_ff[`BIT_HALF];

  core_alu u_alu (
    .p(alu_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // address indirection and write decode
  always_comb begin
    eff_addr = mem_addr;
    if (mem_addr == `ADDR_INDIRECT_0) begin
      eff_addr = memory_pointer_0_ff;
    end else if (mem_addr == `ADDR_INDIRECT_1) begin
      eff_addr = memory_pointer_1_ff;
    end
    // a pointer aimed at an indirection address goes nowhere
    eff_dead = (eff_addr == `ADDR_INDIRECT_0) || (eff_addr == `ADDR_INDIRECT_1);
    alu_to_work = alu_go && !alu_into_mem;
    wr_any = mem_wr || (alu_go && alu_into_mem);
    wr_byte = (alu_go && alu_into_mem) ? alu_bus.res : mem_wdata;
    wr_ok = wr_any && !eff_dead;
    in_ram = (eff_addr >= `RAM_BASE);
    ram_idx = eff_addr - `RAM_BASE;
    ctrl_wr = wr_ok && (eff_addr == `ADDR_IRQ_CTRL);
  end

  ////////////////////////////////////////////////////////////////////////
  // register read mux; unused addresses read zero
  always_comb begin
    reg_rdata = `RESET_BYTE;
    if (!eff_dead) begin
      case (eff_addr)
        `ADDR_PTR_0: reg_rdata = memory_pointer_0_ff;
        `ADDR_PTR_1: reg_rdata = memory_pointer_1_ff;
        `ADDR_WORK: reg_rdata = working_register_ff;
        `ADDR_FLAGS: reg_rdata = result_flags_ff;
        `ADDR_IRQ_CTRL: begin
          // bits 3, 6 and 7 stay zero
          reg_rdata = {2'b00, tick_irq_pending_ff, pin_irq_pending_ff, 1'b0,
                       tick_irq_enable_ff, pin_irq_enable_ff, global_irq_enable_ff};
        end
        default: reg_rdata = `RESET_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // general purpose ram
  core_data_ram #(
    .DEPTH(RAM_DEPTH)
  ) u_ram (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .wr_en(wr_ok && in_ram),
    .idx(ram_idx),
    .wdata(wr_byte),
    .rdata_ff(ram_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // read pipeline: two edges from request to valid data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_pend_ff <= 1'b0;
      rd_ram_ff <= 1'b0;
      rd_reg_ff <= `RESET_BYTE;
      mem_rdata_ff <= `RESET_BYTE;
      mem_rvalid_ff <= 1'b0;
    end else if (clk_en) begin
      rd_pend_ff <= mem_rd;
      rd_ram_ff <= in_ram && !eff_dead;
      rd_reg_ff <= reg_rdata;
      mem_rvalid_ff <= rd_pend_ff;
      if (rd_pend_ff) begin
        mem_rdata_ff <= rd_ram_ff ? ram_q : rd_reg_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memory pointers, plain data-space registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      memory_pointer_0_ff <= `RESET_BYTE;
      memory_pointer_1_ff <= `RESET_BYTE;
    end else if (clk_en && wr_ok) begin
      if (eff_addr == `ADDR_PTR_0) begin
        memory_pointer_0_ff <= wr_byte;
      end
      if (eff_addr == `ADDR_PTR_1) begin
        memory_pointer_1_ff <= wr_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // working register: an alu result other than OP_PASS wins over a data-space write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      working_register_ff <= `RESET_BYTE;
    end else if (clk_en) begin
      if (alu_to_work && alu_op != core_flags_pkg::OP_PASS) begin
        working_register_ff <= alu_bus.res;
      end else if (wr_ok && eff_addr == `ADDR_WORK) begin
        working_register_ff <= wr_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // skip decision from the alu zero output
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      skip_ff <= 1'b0;
    end else if (clk_en) begin
      skip_ff <= alu_go && ((alu_skip_if_zero && alu_bus.z) || (alu_skip_if_nonzero && !alu_bus.z));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result flags: software writes first, alu flags override in the same cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      result_flags_ff <= `RESET_BYTE;
    end else if (clk_en) begin
      if (wr_ok && eff_addr == `ADDR_FLAGS) begin
        // only the low four flags take written data
        result_flags_ff[3:0] <= wr_byte[3:0];
      end
      if (alu_go) begin
        case (alu_op)
          core_flags_pkg::OP_ADD, core_flags_pkg::OP_ADC,
          core_flags_pkg::OP_SUB, core_flags_pkg::OP_SBC: begin
            result_flags_ff[`BIT_CARRY] <= alu_bus.c;
            result_flags_ff[`BIT_HALF] <= alu_bus.h;
            result_flags_ff[`BIT_ZERO] <= alu_bus.z;
            result_flags_ff[`BIT_RANGE] <= alu_bus.ov;
          end
          core_flags_pkg::OP_DAA: result_flags_ff[`BIT_CARRY] <= alu_bus.c;
          core_flags_pkg::OP_RLC, core_flags_pkg::OP_RRC: result_flags_ff[`BIT_CARRY] <= alu_bus.c;
          core_flags_pkg::OP_AND, core_flags_pkg::OP_OR, core_flags_pkg::OP_XOR, core_flags_pkg::OP_CPL,
          core_flags_pkg::OP_INC, core_flags_pkg::OP_DEC: result_flags_ff[`BIT_ZERO] <= alu_bus.z;
          default: result_flags_ff[`BIT_ZERO] <= result_flags_ff[`BIT_ZERO];
        endcase
      end
      // power flags: clear instruction first, halt next, timeout wins last
      if (wdt_clear_exec) begin
        result_flags_ff[`BIT_SLEEP] <= 1'b0;
        result_flags_ff[`BIT_WDOG] <= 1'b0;
      end
      if (halt_exec) begin
        result_flags_ff[`BIT_SLEEP] <= 1'b1;
        result_flags_ff[`BIT_WDOG] <= 1'b0;
      end
      if (wdt_timeout) begin
        result_flags_ff[`BIT_WDOG] <= 1'b1;
      end
      result_flags_ff[7:6] <= 2'b00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin edge detect; first sample after reset never counts as an edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_prev_ff <= 1'b0;
      pin_seen_ff <= 1'b0;
    end else if (clk_en) begin
      pin_prev_ff <= shared_irq_pin;
      pin_seen_ff <= 1'b1;
    end
  end

  // high polarity: rising edge, low polarity: falling edge
  assign pin_event = pin_seen_ff && (edge_polarity_select_line ? (!pin_prev_ff && shared_irq_pin)
                                                               : (pin_prev_ff && !shared_irq_pin));

  ////////////////////////////////////////////////////////////////////////
  // acknowledge decision: pin first, nothing while the stack is full
  always_comb begin
    want_pin = global_irq_enable_ff && pin_irq_enable_ff && pin_irq_pending_ff;
    want_tick = global_irq_enable_ff && tick_irq_enable_ff && tick_irq_pending_ff;
    take_pin = irq_slot && !stack_full_ff && want_pin;
    take_tick = irq_slot && !stack_full_ff && want_tick && !want_pin;
  end

  ////////////////////////////////////////////////////////////////////////
  // enables: software write; master enable cleared on acknowledge, set by interrupt return
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      global_irq_enable_ff <= 1'b0;
      pin_irq_enable_ff <= 1'b0;
      tick_irq_enable_ff <= 1'b0;
    end else if (clk_en) begin
      if (ctrl_wr) begin
        global_irq_enable_ff <= wr_byte[`BIT_GIE];
        pin_irq_enable_ff <= wr_byte[`BIT_PIE];
        tick_irq_enable_ff <= wr_byte[`BIT_TIE];
      end
      if (take_pin || take_tick) begin
        global_irq_enable_ff <= 1'b0;
      end
      if (return_from_irq_pop) begin
        global_irq_enable_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pending flags: hardware set beats acknowledge or software clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_irq_pending_ff <= 1'b0;
      tick_irq_pending_ff <= 1'b0;
    end else if (clk_en) begin
      if (ctrl_wr) begin
        pin_irq_pending_ff <= wr_byte[`BIT_PIN_PEND];
        tick_irq_pending_ff <= wr_byte[`BIT_TICK_PEND];
      end
      if (take_pin) begin
        pin_irq_pending_ff <= 1'b0;
      end
      if (take_tick) begin
        tick_irq_pending_ff <= 1'b0;
      end
      if (pin_event) begin
        pin_irq_pending_ff <= 1'b1;
      end
      if (tick_overflow) begin
        tick_irq_pending_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // vector output: only the return address goes on the stack, flags never do
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_take_ff <= 1'b0;
      irq_vector_ff <= 12'h000;
    end else if (clk_en) begin
      irq_take_ff <= take_pin || take_tick;
      if (take_pin) begin
        irq_vector_ff <= `VEC_PIN;
      end else if (take_tick) begin
        irq_vector_ff <= `VEC_TICK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // return stack occupancy; a call and a return together cancel out
  always_comb begin
    nxt_stack_level = stack_level_ff;
    if ((call_push || take_pin || take_tick) && !(ret_pop || return_from_irq_pop)) begin
      nxt_stack_level = stack_level_ff + 3'd1;
    end else if (!(call_push || take_pin || take_tick) && (ret_pop || return_from_irq_pop) && stack_level_ff != 3'd0) begin
      nxt_stack_level = stack_level_ff - 3'd1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stack_level_ff <= 3'd0;
      stack_full_ff <= 1'b0;
    end else if (clk_en) begin
      // warm restart from a timeout while halted empties the stack
      stack_level_ff <= (wdt_timeout && pwr_ff == core_flags_pkg::PWR_HALT) ? 3'd0 : nxt_stack_level;
      stack_full_ff <= !(wdt_timeout && pwr_ff == core_flags_pkg::PWR_HALT)
                       && (nxt_stack_level >= 3'(STACK_LEVELS));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // halt and wake: any request event wakes, enabled or not
  assign wake_cause = pin_event || tick_overflow || wdt_timeout;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pwr_ff <= core_flags_pkg::PWR_RUN;
      halted_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else if (clk_en) begin
      wake_ff <= 1'b0;
      case (pwr_ff)
        core_flags_pkg::PWR_RUN: begin
          if (halt_exec) begin
            pwr_ff <= core_flags_pkg::PWR_HALT;
            halted_ff <= 1'b1;
          end
        end
        core_flags_pkg::PWR_HALT: begin
          if (wake_cause) begin
            pwr_ff <= core_flags_pkg::PWR_RUN;
            halted_ff <= 1'b0;
            wake_ff <= 1'b1;
          end
        end
        default: begin
          pwr_ff <= core_flags_pkg::PWR_RUN;
          halted_ff <= 1'b0;
        end
      endcase
    end
  end
endmodule

// [rtl/core_flags_regs.svh]
// data-space addresses, bit positions and vectors of the core flag and interrupt logic
`ifndef CORE_FLAGS_REGS_SVH
`define CORE_FLAGS_REGS_SVH
// data-space addresses
`define ADDR_INDIRECT_0 8'h00
`define ADDR_PTR_0 8'h01
`define ADDR_INDIRECT_1 8'h02
`define ADDR_PTR_1 8'h03
`define ADDR_WORK 8'h05
`define ADDR_FLAGS 8'h0a
`define ADDR_IRQ_CTRL 8'h0b
`define RAM_BASE 8'h60
`define RAM_DEPTH 160
// result_flags bit positions
`define BIT_CARRY 0
`define BIT_HALF 1
`define BIT_ZERO 2
`define BIT_RANGE 3
`define BIT_SLEEP 4
`define BIT_WDOG 5
// irq_control_reg bit positions
`define BIT_GIE 0
`define BIT_PIE 1
`define BIT_TIE 2
`define BIT_PIN_PEND 4
`define BIT_TICK_PEND 5
// vectors, stack and reset values
`define VEC_PIN 12'h004
`define VEC_TICK 12'h008
`define STACK_LEVELS 6
`define RESET_BYTE 8'h00
`endif

// [rtl/core_flags_pkg.sv]
// shared types of the core flag and interrupt logic
package core_flags_pkg;
  // alu operations, all on 8 bits
  typedef enum logic [3:0] {
    OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DAA, OP_AND, OP_OR, OP_XOR,
    OP_CPL, OP_RL, OP_RR, OP_RLC, OP_RRC, OP_INC, OP_DEC, OP_PASS
  } alu_op_t;
  // run or halted
  typedef enum logic {PWR_RUN, PWR_HALT} power_state_t;
endpackage

// [rtl/alu_if.sv]
// carrier between the core and its alu
`timescale 1ns/1ps
interface alu_if;
  core_flags_pkg::alu_op_t op; // operation
  logic [7:0] a; // working register
  logic [7:0] b; // second operand
  logic cin; // carry in
  logic hin; // half carry in, for decimal adjust
  logic [7:0] res; // result
  logic c; // carry / no borrow out
  logic h; // half carry out
  logic z; // zero result
  logic ov; // signed range out
  modport core (output op, a, b, cin, hin, input res, c, h, z, ov);
  modport alu (input op, a, b, cin, hin, output res, c, h, z, ov);
endinterface

// [rtl/core_alu.sv]
// 8-bit combinational alu
`timescale 1ns/1ps
module core_alu (
  alu_if.alu p
);
  ////////////////////////////////////////////////////////////////////////
  // add/subtract share one adder: subtract adds the inverted operand
  always_comb begin
    logic [8:0] s;
    logic [4:0] hs;
    logic [7:0] bb;
    logic ci;
    logic [8:0] dj;
    s = 9'h000;
    hs = 5'h00;
    bb = p.b;
    ci = 1'b0;
    dj = 9'h000;
    p.res = p.b;
    p.c = p.cin;
    p.h = p.hin;
    p.ov = 1'b0;
    case (p.op)
      core_flags_pkg::OP_ADD, core_flags_pkg::OP_ADC,
      core_flags_pkg::OP_SUB, core_flags_pkg::OP_SBC: begin
        // subtract: carry out set means no borrow
        bb = (p.op == core_flags_pkg::OP_SUB || p.op == core_flags_pkg::OP_SBC) ? ~p.b : p.b;
        ci = (p.op == core_flags_pkg::OP_ADD) ? 1'b0 : (p.op == core_flags_pkg::OP_SUB) ? 1'b1 : p.cin;
        s = {1'b0, p.a} + {1'b0, bb} + {8'h00, ci};
        hs = {1'b0, p.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        p.res = s[7:0];
        p.c = s[8];
        p.h = hs[4];
        p.ov = (p.a[7] ^ bb[7] ^ s[7]) ^ s[8];
      end
      core_flags_pkg::OP_DAA: begin
        // adjust low then high digit of the working register
        dj = {1'b0, p.a};
        if (p.hin || p.a[3:0] > 4'h9) begin
          dj = dj + 9'h006;
        end
        if (p.cin || dj[8] || dj[7:4] > 4'h9) begin
          dj = dj + 9'h060;
        end
        p.res = dj[7:0];
        p.c = p.cin | dj[8];
      end
      core_flags_pkg::OP_AND: p.res = p.a & p.b;
      core_flags_pkg::OP_OR: p.res = p.a | p.b;
      core_flags_pkg::OP_XOR: p.res = p.a ^ p.b;
      core_flags_pkg::OP_CPL: p.res = ~p.b;
      core_flags_pkg::OP_RL: p.res = {p.b[6:0], p.b[7]};
      core_flags_pkg::OP_RR: p.res = {p.b[0], p.b[7:1]};
      core_flags_pkg::OP_RLC: begin
        p.res = {p.b[6:0], p.cin};
        p.c = p.b[7];
      end
      core_flags_pkg::OP_RRC: begin
        p.res = {p.cin, p.b[7:1]};
        p.c = p.b[0];
      end
      core_flags_pkg::OP_INC: p.res = p.b + 8'h01;
      core_flags_pkg::OP_DEC: p.res = p.b - 8'h01;
      default: p.res = p.b;
    endcase
    p.z = (p.res == 8'h00);
  end
endmodule

// [rtl/core_data_ram.sv]
// general purpose data memory with registered read data
`timescale 1ns/1ps
`include "core_flags_regs.svh"
module core_data_ram #(
  parameter int DEPTH = `RAM_DEPTH
) (
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [7:0] idx,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_ff
);
  logic [7:0] mem [DEPTH]; // storage, no reset: contents undefined at power-up

  ////////////////////////////////////////////////////////////////////////
  // write port and registered read port
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[idx] <= wdata;
      end
      rdata_ff <= mem[idx];
    end
  end
endmodule

// [bench/core_flags_monitor.sv]
// port checks for the core flag and interrupt logic
`timescale 1ns/1ps
module core_flags_monitor (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic mem_rd,
  input wire logic mem_rvalid_ff,
  input wire logic alu_go,
  input wire logic skip_ff,
  input wire logic halt_exec,
  input wire logic wdt_clear_exec,
  input wire logic wdt_timeout,
  input wire logic irq_slot,
  input wire logic tick_overflow,
  input wire logic irq_take_ff,
  input wire logic stack_full_ff,
  input wire logic halted_ff,
  input wire logic wake_ff,
  input wire logic [7:0] result_flags_ff
);
  // one clock, all checks quiet in reset
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // a read taken on an enabled edge
  sequence s_rd;
    mem_rd && clk_en;
  endsequence
  a_read_answer: assert property (s_rd |-> ##2 mem_rvalid_ff)
    else $error("read not answered");
  a_skip_cause: assert property (skip_ff |-> $past(alu_go))
    else $error("skip without alu op");
  a_flags_top: assert property (result_flags_ff[7:6] == 2'h0)
    else $error("flag bits 7:6 set");
  a_halt_flags: assert property (
    halt_exec && clk_en && !halted_ff && !wdt_timeout && !wdt_clear_exec
    |=> result_flags_ff[5:4] == 2'h1 && halted_ff) else $error("halt flags wrong");
  a_clear_flags: assert property (
    wdt_clear_exec && clk_en && !wdt_timeout && !halt_exec |=> result_flags_ff[5:4] == 2'h0)
    else $error("watchdog clear left a flag");
  a_timeout_flag: assert property (wdt_timeout && clk_en |=> result_flags_ff[5])
    else $error("timeout flag not set");
  a_take_gate: assert property (irq_take_ff |-> $past(irq_slot) && !$past(stack_full_ff))
    else $error("acknowledge out of slot or stack full");
  a_wake_tick: assert property (halted_ff && tick_overflow && clk_en |=> wake_ff && !halted_ff)
    else $error("overflow did not wake");
endmodule
bind core_flags_and_interrupt_logic core_flags_monitor u_core_flags_monitor (.*);

// [bench/irq_source_model.sv]
// far side: interrupt pin and timer overflow source
`timescale 1ns/1ps
module irq_source_model (
  input wire logic sys_clk,
  output logic shared_irq_pin,
  output logic tick_overflow
);
  // pin rests low, timer quiet until told
  initial begin
    shared_irq_pin = 1'b0;
    tick_overflow = 1'b0;
  end
  // level moves on a rising edge so the core samples it clean
  task automatic set_pin(input logic lvl);
    @(posedge sys_clk);
    shared_irq_pin <= lvl;
  endtask
  // one-cycle overflow, as a counter wrap gives
  task automatic pulse_tick();
    @(posedge sys_clk);
    tick_overflow <= 1'b1;
    @(posedge sys_clk);
    tick_overflow <= 1'b0;
  endtask
endmodule

// [bench/core_flags_and_interrupt_logic_tb.sv]
// self-checking bench for the core flag and interrupt logic
`timescale 1ns/1ps
module core_flags_and_interrupt_logic_tb;
  // inputs idle, reset held from time zero
  logic sys_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, mem_rd = 1'b0, mem_wr = 1'b0, alu_go = 1'b0;
  logic alu_into_mem = 1'b0, alu_skip_if_zero = 1'b0, alu_skip_if_nonzero = 1'b0, call_push = 1'b0;
  logic ret_pop = 1'b0, edge_polarity_select_line = 1'b0, took;
  logic [4:0] strb = 5'h00; // halt, wd clear, timeout, interrupt return, slot
  wire halt_exec = strb[0], wdt_clear_exec = strb[1], wdt_timeout = strb[2], return_from_irq_pop = strb[3], irq_slot = strb[4];
  logic [7:0] mem_addr = 8'h00, mem_wdata = 8'h00, alu_operand = 8'h00;
  core_flags_pkg::alu_op_t alu_op = core_flags_pkg::OP_PASS;
  logic shared_irq_pin, tick_overflow, mem_rvalid_ff, skip_ff, irq_take_ff, stack_full_ff, wake_ff, halted_ff;
  logic [7:0] mem_rdata_ff, working_register_ff, result_flags_ff;
  logic [11:0] irq_vector_ff;
  int num_errors = 0;
  int cmp_count = 0;
  core_flags_and_interrupt_logic u_core_flags_and_interrupt_logic (.*);
  irq_source_model u_irq_source_model (.*);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // bus tasks start and end just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mem_wr <= 1'b1;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge sys_clk);
    mem_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  // a missing strobe turns the data into its inverse, so it fails
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    mem_rd <= 1'b1;
    mem_addr <= a;
    @(posedge sys_clk);
    mem_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(mem_rvalid_ff ? mem_rdata_ff : ~e, e);
    @(posedge sys_clk);
  endtask
  task automatic alu(input core_flags_pkg::alu_op_t op, input logic [7:0] b, input logic s, input logic [7:0] ew,
                     input logic [7:0] ef);
    alu_go <= 1'b1;
    alu_op <= op;
    alu_operand <= b;
    alu_skip_if_zero <= s;
    @(posedge sys_clk);
    alu_go <= 1'b0;
    alu_skip_if_zero <= 1'b0;
    #1;
    chk(working_register_ff, ew);
    chk(result_flags_ff, ef);
    chk({7'h0, skip_ff}, {7'h0, s});
    @(posedge sys_clk);
  endtask
  // one-cycle strobe; acknowledge caught in the cycle it stands
  task automatic pulse(input logic [4:0] m);
    strb <= m;
    @(posedge sys_clk);
    strb <= 5'h00;
    #1;
    took = irq_take_ff;
    @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_pointers();
    wr(8'h01, 8'h60);
    wr(8'h00, 8'h5a);
    rd(8'h60, 8'h5a);
    rd(8'h01, 8'h60);
    wr(8'h03, 8'h02);
    wr(8'h02, 8'h77);
    rd(8'h02, 8'h00);
    wr(8'h05, 8'h33);
    rd(8'h05, 8'h33);
    // enable low: a write must not land
    clk_en <= 1'b0;
    wr(8'h05, 8'hee);
    clk_en <= 1'b1;
    rd(8'h05, 8'h33);
  endtask
  task automatic t_alu();
    wr(8'h05, 8'h7f);
    alu(core_flags_pkg::OP_ADD, 8'h01, 1'b0, 8'h80, 8'h0a);
    alu(core_flags_pkg::OP_SUB, 8'h80, 1'b1, 8'h00, 8'h07);
    alu(core_flags_pkg::OP_RLC, 8'h01, 1'b0, 8'h03, 8'h06);
    alu(core_flags_pkg::OP_XOR, 8'h01, 1'b0, 8'h02, 8'h02);
    alu(core_flags_pkg::OP_DAA, 8'h00, 1'b0, 8'h08, 8'h02);
    alu(core_flags_pkg::OP_ADC, 8'hf8, 1'b1, 8'h00, 8'h07);
    wr(8'h0a, 8'hff);
    rd(8'h0a, 8'h0f);
  endtask
  task automatic t_halt();
    pulse(5'h01);
    chk(result_flags_ff, 8'h1f);
    u_irq_source_model.pulse_tick();
    #1;
    chk({7'h0, wake_ff}, 8'h01);
    @(posedge sys_clk);
    chk({7'h0, halted_ff}, 8'h00);
    pulse(5'h04);
    chk(result_flags_ff, 8'h3f);
    pulse(5'h02);
    chk(result_flags_ff, 8'h0f);
  endtask
  // both sources at once, then nesting gate and falling edge
  task automatic t_irq();
    wr(8'h0b, 8'h07);
    edge_polarity_select_line <= 1'b1;
    fork
      u_irq_source_model.set_pin(1'b1);
      u_irq_source_model.pulse_tick();
    join
    pulse(5'h10);
    chk({7'h0, took}, 8'h01);
    chk(irq_vector_ff[7:0], 8'h04);
    rd(8'h0b, 8'h26);
    pulse(5'h08);
    pulse(5'h10);
    chk({took, irq_vector_ff[6:0]}, 8'h88);
    rd(8'h0b, 8'h06);
    edge_polarity_select_line <= 1'b0;
    u_irq_source_model.set_pin(1'b0);
    @(posedge sys_clk);
    rd(8'h0b, 8'h16);
  endtask
  // full stack holds the pin request back; a plain return keeps the master enable
  task automatic t_stack();
    call_push <= 1'b1;
    repeat (5) @(posedge sys_clk);
    call_push <= 1'b0;
    #1;
    chk({7'h0, stack_full_ff}, 8'h01);
    @(posedge sys_clk);
    wr(8'h0b, 8'h17);
    pulse(5'h10);
    chk({7'h0, took}, 8'h00);
    ret_pop <= 1'b1;
    @(posedge sys_clk);
    ret_pop <= 1'b0;
    rd(8'h0b, 8'h17);
    chk({7'h0, stack_full_ff}, 8'h00);
    pulse(5'h10);
    chk({took, irq_vector_ff[6:0]}, 8'h84);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // hang guard, far past the hundred or so cycles needed
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_pointers();
    t_alu();
    t_halt();
    t_irq();
    t_stack();
    complete_run();
  end
endmodule
